// ---- hdl/pmr_pkg.sv ----
// package for the power mode control and retention block
package pmr_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_POWER_MODE_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RETENTION_SCRATCH_0 = 8'h04;
    localparam logic [7:0] OFF_RETENTION_SCRATCH_1 = 8'h08;
    localparam logic [7:0] OFF_RETENTION_SCRATCH_2 = 8'h0c;
    localparam logic [7:0] OFF_RETENTION_SCRATCH_3 = 8'h10;
    localparam logic [7:0] OFF_RETENTION_SCRATCH_WAKE_HYSTERESIS = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

    // power mode control fields
    localparam int DEEP_POWERDOWN_SELECT_BIT = 1;
    localparam int SLEEP_ENTERED_FLAG_BIT = 8;
    localparam int DEEP_POWERDOWN_ENTERED_FLAG_BIT = 11;

    // wake hysteresis register fields
    localparam int WAKE_PIN_HYSTERESIS_ENABLE_BIT = 10;
    localparam int RETAINED_DATA_LSB = 11;
    localparam logic [31:0] HYST_REG_WRITE_MASK = 32'hfffffc00;

    // interrupt status bits
    localparam int IRQ_SLEEP_BIT = 0;
    localparam int IRQ_DEEP_POWERDOWN_BIT = 1;
    localparam logic [31:0] IRQ_VALID_MASK = 32'h00000003;

    // reset values
    localparam logic [31:0] POWER_MODE_CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] RETENTION_RESET = 32'h00000000;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    localparam int NUM_SCRATCH = 5;

    typedef enum logic [1:0] {
        PMR_ACTIVE,
        PMR_SLEEP,
        PMR_DEEP_POWERDOWN
    } pmr_mode_t;

    typedef struct packed {
        pmr_mode_t mode;
        logic deepPowerdownSelect;
        logic sleepEnteredFlag;
        logic deepPowerdownEnteredFlag;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic [31:0] readData;
    } pmr_state_t;

endpackage

// ---- hdl/pmr_power_mode_control.sv ----
// power mode control and retention registers
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - select bit 1 chooses sleep (0) or deep power-down (1) on wait-for-interrupt.
// - sleep flag bit 8 sets on any low-power entry; write 1 clears it.
// - deep power-down flag bit 11 sets on deep power-down entry; write 1 clears.
// - four 32-bit retention registers keep contents through deep power-down.
// - retention registers reset only by cold power-on, not by other resets.
// - fifth retention register keeps data bits 31:11 like the others.
// - bit 10 of fifth retention register drives wake pin hysteresis; resets 0.
module pmr_power_mode_control (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic coldRst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    // core sleep interface
    input wire logic sleepRequest,
    input wire logic wakeEvent,
    output logic coreClockStop,
    output logic corePowerOff,
    // pins and interrupt
    output logic wakePinHysteresisEnable,
    output logic irq
);

    pmr_pkg::pmr_state_t state;
    pmr_pkg::pmr_state_t next_state;
    logic [31:0] scratch [pmr_pkg::NUM_SCRATCH];
    logic [31:0] powerControl;
    logic [31:0] muxData;
    logic wrPower;
    logic enterSleep;
    logic enterDeep;
    logic [2:0] wordIndex;
    logic addrInScratch;

    assign wrPower = regWrite && regAddr == pmr_pkg::OFF_POWER_MODE_CONTROL;
    assign wordIndex = regAddr[4:2] - 3'h1;
    assign addrInScratch = regAddr[1:0] == 2'h0 && regAddr >= pmr_pkg::OFF_RETENTION_SCRATCH_0
        && regAddr <= pmr_pkg::OFF_RETENTION_SCRATCH_WAKE_HYSTERESIS;
    // entries only from active mode, so a held request does not re-trigger
    assign enterSleep = state.mode == pmr_pkg::PMR_ACTIVE && sleepRequest && !state.deepPowerdownSelect;
    assign enterDeep = state.mode == pmr_pkg::PMR_ACTIVE && sleepRequest && state.deepPowerdownSelect;

    always_comb begin
        powerControl = pmr_pkg::POWER_MODE_CONTROL_RESET;
        powerControl[pmr_pkg::DEEP_POWERDOWN_SELECT_BIT] = state.deepPowerdownSelect;
        powerControl[pmr_pkg::SLEEP_ENTERED_FLAG_BIT] = state.sleepEnteredFlag;
        powerControl[pmr_pkg::DEEP_POWERDOWN_ENTERED_FLAG_BIT] = state.deepPowerdownEnteredFlag;
    end

    always_comb begin
        case (regAddr)
            pmr_pkg::OFF_POWER_MODE_CONTROL: muxData = powerControl;
            pmr_pkg::OFF_IRQ_STATUS: muxData = {30'h0, state.irqStatus};
            pmr_pkg::OFF_IRQ_MASK: muxData = {30'h0, state.irqMask};
            default: begin
                muxData = addrInScratch ? scratch[wordIndex] : 32'h00000000;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.readData = regRead ? muxData : state.readData;
        // mode sequencing
        case (state.mode)
            pmr_pkg::PMR_ACTIVE: begin
                if (enterDeep) begin
                    next_state.mode = pmr_pkg::PMR_DEEP_POWERDOWN;
                end else if (enterSleep) begin
                    next_state.mode = pmr_pkg::PMR_SLEEP;
                end
            end
            pmr_pkg::PMR_SLEEP, pmr_pkg::PMR_DEEP_POWERDOWN: begin
                if (wakeEvent) begin
                    next_state.mode = pmr_pkg::PMR_ACTIVE;
                end
            end
            default: next_state.mode = pmr_pkg::PMR_ACTIVE;
        endcase
        // control writes; reserved bits are simply not stored
        if (wrPower) begin
            next_state.deepPowerdownSelect = regWriteData[pmr_pkg::DEEP_POWERDOWN_SELECT_BIT];
            if (regWriteData[pmr_pkg::SLEEP_ENTERED_FLAG_BIT]) begin
                next_state.sleepEnteredFlag = 1'b0;
            end
            if (regWriteData[pmr_pkg::DEEP_POWERDOWN_ENTERED_FLAG_BIT]) begin
                next_state.deepPowerdownEnteredFlag = 1'b0;
            end
        end
        // a new entry wins over a same-cycle clear
        if (enterSleep || enterDeep) begin
            next_state.sleepEnteredFlag = 1'b1;
        end
        if (enterDeep) begin
            next_state.deepPowerdownEnteredFlag = 1'b1;
        end
        // interrupt status: read clears, set wins
        if (regRead && regAddr == pmr_pkg::OFF_IRQ_STATUS) begin
            next_state.irqStatus = 2'h0;
        end
        if (regWrite && regAddr == pmr_pkg::OFF_IRQ_MASK) begin
            next_state.irqMask = regWriteData[1:0] & pmr_pkg::IRQ_VALID_MASK[1:0];
        end
        if (enterSleep || enterDeep) begin
            next_state.irqStatus[pmr_pkg::IRQ_SLEEP_BIT] = 1'b1;
        end
        if (enterDeep) begin
            next_state.irqStatus[pmr_pkg::IRQ_DEEP_POWERDOWN_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state.mode <= pmr_pkg::PMR_ACTIVE;
            state.deepPowerdownSelect <= 1'b0;
            state.sleepEnteredFlag <= 1'b0;
            state.deepPowerdownEnteredFlag <= 1'b0;
            state.irqStatus <= pmr_pkg::IRQ_RESET;
            state.irqMask <= pmr_pkg::IRQ_RESET;
            state.readData <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end

    // retention storage sits on the cold reset only, so warm resets and
    // deep power-down exit keep it; the always-on supply is assumed here
    genvar gi;
    generate
        for (gi = 0; gi < pmr_pkg::NUM_SCRATCH; gi++) begin : g_scratch
            logic [31:0] writeMask;
            assign writeMask = (gi == pmr_pkg::NUM_SCRATCH - 1) ? pmr_pkg::HYST_REG_WRITE_MASK : 32'hffffffff;
            always_ff @(posedge clk or posedge coldRst) begin
                if (coldRst) begin
                    scratch[gi] <= pmr_pkg::RETENTION_RESET;
                end else if (regWrite && addrInScratch && wordIndex == 3'(gi)) begin
                    scratch[gi] <= regWriteData & writeMask;
                end
            end
        end
    endgenerate

    assign wakePinHysteresisEnable =
        scratch[pmr_pkg::NUM_SCRATCH - 1][pmr_pkg::WAKE_PIN_HYSTERESIS_ENABLE_BIT];
    assign coreClockStop = state.mode != pmr_pkg::PMR_ACTIVE;
    assign corePowerOff = state.mode == pmr_pkg::PMR_DEEP_POWERDOWN;
    assign regReadData = state.readData;
    assign irq = |(state.irqStatus & state.irqMask);

endmodule

// ---- tb/pmr_power_mode_control_properties.sv ----
// checker for the power mode control block
`timescale 1ns/1ps
module pmr_checker (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic coldRst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    // core side and pins
    input wire logic sleepRequest,
    input wire logic wakeEvent,
    input wire logic coreClockStop,
    input wire logic corePowerOff,
    input wire logic wakePinHysteresisEnable,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst || coldRst);
    a_sleep_stops_clock: assert property (sleepRequest && !coreClockStop |=> coreClockStop) else $error("no stop");
    a_off_means_stopped: assert property (corePowerOff |-> coreClockStop) else $error("off but clocked");
    a_wake_resumes: assert property (coreClockStop && wakeEvent |=> !coreClockStop) else $error("no wake");
    a_unmapped_reads_zero: assert property (regRead && regAddr > 8'h1c |=> regReadData == 32'h0) else $error("bad");
    a_reserved_read_zero: assert property (regRead && regAddr == 8'h00 |=> (regReadData & 32'hfffff6fd) == 32'h0)
        else $error("reserved set");
    a_read_data_holds: assert property (!regRead |=> $stable(regReadData)) else $error("data moved");
    a_hyst_follows_write: assert property (regWrite && regAddr == 8'h14 |=> wakePinHysteresisEnable == $past(regWriteData[10]))
        else $error("hyst");
    a_irq_read_clear: assert property (regRead && regAddr == 8'h18 && !sleepRequest |=> !irq) else $error("irq");
endmodule
bind pmr_power_mode_control pmr_checker u_chk (.clk(clk), .rst(rst), .coldRst(coldRst), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .sleepRequest(sleepRequest), .wakeEvent(wakeEvent), .coreClockStop(coreClockStop),
    .corePowerOff(corePowerOff), .wakePinHysteresisEnable(wakePinHysteresisEnable), .irq(irq));

// ---- tb/pmr_core_model.sv ----
// behavioural core issuing sleep requests and wake events
`timescale 1ns/1ps
module pmr_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench commands and block side
    input wire logic doWfi,
    input wire logic doWake,
    input wire logic coreClockStop,
    output logic sleepRequest,
    output logic wakeEvent
);
    // a stopped core cannot keep asking, so the request drops once the clock stops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleepRequest <= 1'b0;
            wakeEvent <= 1'b0;
        end else begin
            sleepRequest <= doWfi && !coreClockStop;
            wakeEvent <= doWake && coreClockStop;
        end
    end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, coldRst = 1'b1, regWrite = 1'b0, regRead = 1'b0, doWfi = 1'b0, doWake = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWriteData = 32'h0, regReadData;
    logic sleepRequest, wakeEvent, coreClockStop, corePowerOff, wakePinHysteresisEnable, irq;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    logic [31:0] val [7];
    int n_mismatch = 0;
    int tests_run = 0;
    pmr_power_mode_control DUT (.clk(clk), .rst(rst), .coldRst(coldRst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .sleepRequest(sleepRequest), .wakeEvent(wakeEvent), .coreClockStop(coreClockStop),
        .corePowerOff(corePowerOff), .wakePinHysteresisEnable(wakePinHysteresisEnable), .irq(irq));
    pmr_core_model u_core (.clk(clk), .rst(rst), .doWfi(doWfi), .doWake(doWake),
        .coreClockStop(coreClockStop), .sleepRequest(sleepRequest), .wakeEvent(wakeEvent));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(regReadData, e);
    endtask
    task automatic nap(input logic [31:0] sel);
        wr(8'h00, sel);
        doWfi <= 1'b1;
        repeat (8) @(posedge clk);
        doWfi <= 1'b0;
        chk({coreClockStop, corePowerOff}, {1'b1, sel[1]});
        doWake <= 1'b1;
        repeat (4) @(posedge clk);
        doWake <= 1'b0;
        chk(coreClockStop, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        coldRst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(offs[i], 32'h0);
        $display("test reset values done");
        for (int i = 1; i < 7; i++) begin
            val[i] = 32'hfffffc00 ^ {i[7:0], 24'h0};
            wr(offs[i], val[i]);
        end
        val[6] = 32'h0;
        for (int i = 1; i < 7; i++) rd(offs[i], val[i]);
        chk(wakePinHysteresisEnable, 32'h1);
        $display("test retention done");
        nap(32'h0);
        chk(irq, 32'h0);
        rd(8'h00, 32'h100);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h100);
        wr(8'h1c, 32'h3);
        @(negedge clk);
        chk(irq, 32'h1);
        rd(8'h18, 32'h1);
        chk(irq, 32'h0);
        wr(8'h00, 32'h100);
        rd(8'h00, 32'h0);
        $display("test sleep done");
        val[5] = 32'hfffff800;
        wr(8'h14, val[5]);
        @(negedge clk);
        chk(wakePinHysteresisEnable, 32'h0);
        nap(32'h2);
        rd(8'h00, 32'h902);
        rd(8'h18, 32'h3);
        wr(8'h00, 32'h902);
        rd(8'h00, 32'h2);
        $display("test deep powerdown done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        for (int i = 1; i < 6; i++) rd(offs[i], val[i]);
        $display("test warm reset done");
        coldRst <= 1'b1;
        @(posedge clk);
        coldRst <= 1'b0;
        for (int i = 1; i < 6; i++) rd(offs[i], 32'h0);
        chk(wakePinHysteresisEnable, 32'h0);
        $display("test cold reset done");
        tally_and_finish();
    end
endmodule
